//--- shared/mchcs_consts.svh
// Register offsets, field positions, codes, reset values and counts of the card host block.
`ifndef MCHCS_CONSTS_SVH
`define MCHCS_CONSTS_SVH
`define MCHCS_MR 8'h04
`define MCHCS_DTOR 8'h08
`define MCHCS_ARGR 8'h10
`define MCHCS_CMDR 8'h14
`define MCHCS_RSPR_HI 4'h2
`define MCHCS_RDR 8'h30
`define MCHCS_TDR 8'h34
`define MCHCS_SR 8'h40
`define MCHCS_IMR 8'h4C
`define MCHCS_RCR 8'h50
`define MCHCS_RNCR 8'h54
`define MCHCS_TCR 8'h58
`define MCHCS_TNCR 8'h5C
`define MCHCS_F_IDX 5:0
`define MCHCS_F_RTYP 7:6
`define MCHCS_F_LAT 12
`define MCHCS_F_TRANSFER_COMMAND_FIELD 17:16
`define MCHCS_F_TRANSFER_DIRECTION 18
`define MCHCS_F_TRANSFER_TYPE_FIELD 21:19
`define MCHCS_F_PAD 14
`define MCHCS_F_PDC 15
`define MCHCS_F_BLKW 31:18
`define MCHCS_F_DCYC 3:0
`define MCHCS_F_DMUL 6:4
`define MCHCS_TR_START 2'h1
`define MCHCS_TR_STOP 2'h2
`define MCHCS_TT_MULTI 3'h1
`define MCHCS_TT_STREAM 3'h2
`define MCHCS_RT_NONE 2'h0
`define MCHCS_RT_LONG 2'h2
`define MCHCS_LAT_SHORT 7'h05
`define MCHCS_LAT_LONG 7'h40
`define MCHCS_CRC7_POLY 7'h09
`define MCHCS_CRC16_POLY 16'h1021
`define MCHCS_CRC_OK 3'h2
`define MCHCS_HSIZE_WORD 3'h2
`define MCHCS_SR_RST 32'h0000C025
`endif

//--- shared/mchcs_pkg.sv
// Types of the card host block: state codes, flag layout and the state record.
package mchcs_pkg;
  typedef enum logic [3:0] {
    C_IDLE = 4'h1, C_SEND = 4'h2, C_WAIT = 4'h4, C_RESP = 4'h8
  } mchcs_cst_t;
  typedef enum logic [9:0] {
    D_IDLE = 10'h001, D_TXS = 10'h002, D_TXD = 10'h004, D_TXC = 10'h008, D_TXE = 10'h010,
    D_STAT = 10'h020, D_BUSY = 10'h040, D_RXW = 10'h080, D_RXD = 10'h100, D_RXC = 10'h200
  } mchcs_dst_t;
  typedef struct packed {
    logic transmit_starved, receive_lost;
    logic [6:0] rsv_hi;
    logic data_timeout, block_checksum_error, response_timeout, response_stop_bit_error;
    logic response_checksum_error, response_direction_error, response_index_error;
    logic transmit_buffers_empty, receive_buffers_full;
    logic [3:0] rsv_mid;
    logic slot_b_card_irq, slot_a_card_irq;
    logic transmit_count_done, receive_count_done, card_idle, transfer_active;
    logic block_end, transmit_word_taken, receive_word_ready, command_done;
  } mchcs_flags_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hresp, rdyo, wr;
    logic [7:0] wa;
    logic [31:0] mode, dtor, arg, imr;
    logic [5:0] idx;
    logic [1:0] rtyp, transfer_command_field;
    logic lat, dir;
    logic [2:0] ttyp;
    mchcs_cst_t cst;
    mchcs_dst_t dst;
    logic [135:0] csh;
    logic [7:0] cbit;
    logic [6:0] lcnt;
    logic [127:0] rsp;
    logic [1:0] rptr;
    logic start_p, stop_p, tx_full;
    logic [31:0] dsh, rdr, tdr;
    logic [15:0] crc, rcr, rncr, tcr, tncr;
    logic [4:0] bidx;
    logic [13:0] wleft;
    logic [24:0] tcnt;
    mchcs_flags_t sr;
    logic [2:0] cks, cmds, dats;
    logic clkf, cmdf, datf, co, coen, dout, doen, irq;
  } mchcs_st_t;
endpackage : mchcs_pkg

//--- rtl/mchcs_top.sv
// Card host command issue, data transfer and status flags behind an AHB-Lite slave.
`include "mchcs_consts.svh"

module mchcs_top (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic hready,
  input logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic card_clk,
  input logic cmd_in,
  output logic cmd_out,
  output logic cmd_oe_n,
  input logic dat0_in,
  output logic dat0_out,
  output logic dat0_oe_n,
  output logic irq
);
  import mchcs_pkg::*;

  mchcs_st_t q;
  mchcs_st_t d;
  logic ap;
  logic ce;

  // Address phase strobe, and the card clock rising edge seen after filtering.
  assign ap = hsel & htrans[1] & hready & (haddr[31:8] == 24'h0);
  assign ce = q.cks[1] & q.cks[2] & ~q.clkf;

  // Seven-bit frame checksum over the first 40 bits of a command or response.
  function automatic logic [6:0] crc7(input logic [39:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'h0} ^ ((c[6] ^ v[i]) ? `MCHCS_CRC7_POLY : 7'h00);
    end
    return c;
  endfunction : crc7

  // One bit step of the sixteen-bit data checksum.
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic b);
    return {c[14:0], 1'h0} ^ ((c[15] ^ b) ? `MCHCS_CRC16_POLY : 16'h0000);
  endfunction : crc16

  // Next state of the whole block.
  always_comb begin
    logic [6:0] lim;
    logic [4:0] msh;
    logic [24:0] tlim;
    logic last, tdec, rdec, ld;
    logic [135:0] nsh;
    logic [39:0] f40;
    d = q;
    lim = q.lat ? `MCHCS_LAT_LONG : `MCHCS_LAT_SHORT;
    msh = 5'h00;
    tdec = 1'h0;
    rdec = 1'h0;
    ld = 1'h0;
    nsh = {q.csh[134:0], q.cmdf};
    f40 = {2'h1, hwdata[`MCHCS_F_IDX], q.arg};
    last = ((q.ttyp != `MCHCS_TT_MULTI) && (q.ttyp != `MCHCS_TT_STREAM)) || q.stop_p;
    unique case (q.dtor[`MCHCS_F_DMUL])
      3'h0: msh = 5'h00;
      3'h1: msh = 5'h04;
      3'h2: msh = 5'h07;
      3'h3: msh = 5'h08;
      3'h4: msh = 5'h0A;
      3'h5: msh = 5'h0C;
      3'h6: msh = 5'h10;
      3'h7: msh = 5'h14;
    endcase
    tlim = 25'(q.dtor[`MCHCS_F_DCYC]) << msh;
    d.rdyo = 1'h1;
    d.hresp = 1'h0;

    // Pin synchronisers; a change counts once the last two stages agree.
    d.cks = {q.cks[1:0], card_clk};
    d.cmds = {q.cmds[1:0], cmd_in};
    d.dats = {q.dats[1:0], dat0_in};
    if (q.cks[1] == q.cks[2]) d.clkf = q.cks[2];
    if (q.cmds[1] == q.cmds[2]) d.cmdf = q.cmds[2];
    if (q.dats[1] == q.dats[2]) d.datf = q.dats[2];

    // Data phase of a write taken in the previous cycle.
    if (q.wr) begin
      unique case (q.wa)
        `MCHCS_MR: d.mode = hwdata;
        `MCHCS_DTOR: d.dtor = hwdata;
        `MCHCS_ARGR: d.arg = hwdata;
        `MCHCS_IMR: d.imr = hwdata;
        `MCHCS_TDR: begin
          d.tdr = hwdata;
          d.tx_full = 1'h1;
          tdec = 1'h1;
        end
        `MCHCS_RCR: begin
          d.rcr = hwdata[15:0];
          d.sr.receive_count_done = 1'h0;
        end
        `MCHCS_RNCR: begin
          d.rncr = hwdata[15:0];
          d.sr.receive_count_done = 1'h0;
        end
        `MCHCS_TCR: begin
          d.tcr = hwdata[15:0];
          d.sr.transmit_count_done = 1'h0;
        end
        `MCHCS_TNCR: begin
          d.tncr = hwdata[15:0];
          d.sr.transmit_count_done = 1'h0;
        end
        `MCHCS_CMDR: begin
          if (q.sr.command_done) begin
            d.idx = hwdata[`MCHCS_F_IDX];
            d.rtyp = hwdata[`MCHCS_F_RTYP];
            d.lat = hwdata[`MCHCS_F_LAT];
            d.transfer_command_field = hwdata[`MCHCS_F_TRANSFER_COMMAND_FIELD];
            d.dir = hwdata[`MCHCS_F_TRANSFER_DIRECTION];
            d.ttyp = hwdata[`MCHCS_F_TRANSFER_TYPE_FIELD];
            d.sr.command_done = 1'h0;
            d.sr.response_index_error = 1'h0;
            d.sr.response_direction_error = 1'h0;
            d.sr.response_checksum_error = 1'h0;
            d.sr.response_stop_bit_error = 1'h0;
            d.sr.response_timeout = 1'h0;
            d.csh = {f40, crc7(f40), 1'h1, 88'h0};
            d.cbit = 8'h00;
            d.lcnt = 7'h00;
            d.cst = C_SEND;
            if (hwdata[`MCHCS_F_TRANSFER_COMMAND_FIELD] == `MCHCS_TR_START) begin
              d.start_p = 1'h1;
              d.sr.receive_lost = 1'h0;
              d.sr.transmit_starved = 1'h0;
            end
            if (hwdata[`MCHCS_F_TRANSFER_COMMAND_FIELD] == `MCHCS_TR_STOP) d.stop_p = 1'h1;
          end
        end
        default: ;
      endcase
    end

    // Address phase: reads answer in the data phase with no wait state.
    d.wr = ap & hwrite & (hsize == `MCHCS_HSIZE_WORD);
    d.wa = haddr[7:0];
    d.hrdata = 32'h0;
    if (ap && !hwrite) begin
      if (haddr[7:4] == `MCHCS_RSPR_HI) begin
        d.hrdata = q.rsp[{~q.rptr, 5'h00} +: 32];
        d.rptr = q.rptr + 2'h1;
      end else begin
        unique case (haddr[7:0])
          `MCHCS_MR: d.hrdata = q.mode;
          `MCHCS_DTOR: d.hrdata = q.dtor;
          `MCHCS_ARGR: d.hrdata = q.arg;
          `MCHCS_IMR: d.hrdata = q.imr;
          `MCHCS_RCR: d.hrdata = {16'h0, q.rcr};
          `MCHCS_RNCR: d.hrdata = {16'h0, q.rncr};
          `MCHCS_TCR: d.hrdata = {16'h0, q.tcr};
          `MCHCS_TNCR: d.hrdata = {16'h0, q.tncr};
          `MCHCS_RDR: begin
            d.hrdata = q.rdr;
            d.sr.receive_word_ready = 1'h0;
            rdec = 1'h1;
          end
          `MCHCS_SR: begin
            d.hrdata = q.sr;
            d.sr.block_end = 1'h0;
            d.sr.block_checksum_error = 1'h0;
            d.sr.data_timeout = 1'h0;
          end
          default: d.hrdata = 32'h0;
        endcase
      end
    end

    // Command line: frame out, wait for the answer, take it in and check it.
    if (ce) begin
      d.co = 1'h1;
      d.coen = 1'h1;
      unique case (q.cst)
        C_IDLE: ;
        C_SEND: begin
          d.co = q.csh[135];
          d.coen = 1'h0;
          d.csh = {q.csh[134:0], 1'h0};
          d.cbit = q.cbit + 8'h01;
          if (q.cbit == 8'd47) begin
            d.cst = (q.rtyp == `MCHCS_RT_NONE) ? C_IDLE : C_WAIT;
            d.sr.command_done = (q.rtyp == `MCHCS_RT_NONE);
          end
        end
        C_WAIT: begin
          if (!q.cmdf) begin
            d.csh = 136'h0;
            d.cbit = 8'h01;
            d.cst = C_RESP;
          end else if (q.lcnt == lim) begin
            d.sr.response_timeout = 1'h1;
            d.sr.command_done = 1'h1;
            d.cst = C_IDLE;
          end else begin
            d.lcnt = q.lcnt + 7'h01;
          end
        end
        C_RESP: begin
          d.csh = nsh;
          d.cbit = q.cbit + 8'h01;
          if (q.cbit == ((q.rtyp == `MCHCS_RT_LONG) ? 8'd135 : 8'd47)) begin
            d.rptr = 2'h0;
            d.cst = C_IDLE;
            d.sr.command_done = 1'h1;
            if (!nsh[0]) d.sr.response_stop_bit_error = 1'h1;
            if (q.rtyp == `MCHCS_RT_LONG) begin
              d.rsp = nsh[127:0];
              if (nsh[134]) d.sr.response_direction_error = 1'h1;
            end else begin
              d.rsp = {nsh[39:8], 96'h0};
              if (nsh[46]) d.sr.response_direction_error = 1'h1;
              if (nsh[45:40] != q.idx) d.sr.response_index_error = 1'h1;
              if (nsh[7:1] != crc7(nsh[47:8])) d.sr.response_checksum_error = 1'h1;
            end
            if (q.transfer_command_field == `MCHCS_TR_START && !q.dir) d.sr.card_idle = 1'h0;
          end
        end
      endcase
    end

    // Data line: block write with status and busy, or block read with checksum.
    d.tcnt = q.tcnt + 25'h1;
    unique case (q.dst)
      D_IDLE: begin
        d.stop_p = 1'h0;
        if (q.start_p && q.cst == C_IDLE && q.sr.command_done) begin
          d.start_p = 1'h0;
          d.sr.transfer_active = 1'h1;
          d.tcnt = 25'h0;
          d.dst = q.dir ? D_RXW : D_TXS;
        end
      end
      D_TXS: if (ce) begin
        d.dout = 1'h0;
        d.doen = 1'h0;
        d.crc = 16'h0;
        d.bidx = 5'h00;
        d.wleft = q.mode[`MCHCS_F_BLKW];
        ld = 1'h1;
        d.dst = D_TXD;
      end
      D_TXD: if (ce) begin
        d.dout = q.dsh[31];
        d.crc = crc16(q.crc, q.dsh[31]);
        d.dsh = {q.dsh[30:0], 1'h0};
        d.bidx = q.bidx + 5'h01;
        if (q.bidx == 5'h1F) begin
          if (q.wleft <= 14'h1) begin
            d.dst = D_TXC;
          end else begin
            d.wleft = q.wleft - 14'h1;
            ld = 1'h1;
          end
        end
      end
      D_TXC: if (ce) begin
        d.dout = q.crc[15];
        d.crc = {q.crc[14:0], 1'h0};
        d.bidx = q.bidx + 5'h01;
        if (q.bidx == 5'h0F) d.dst = D_TXE;
      end
      D_TXE: if (ce) begin
        d.dout = 1'h1;
        d.bidx = 5'h00;
        d.dst = D_STAT;
        if (last) d.sr.transfer_active = 1'h0;
      end
      D_STAT: if (ce) begin
        d.doen = 1'h1;
        if (q.bidx == 5'h00) begin
          if (!q.datf) d.bidx = 5'h01;
        end else begin
          d.dsh = {q.dsh[30:0], q.datf};
          d.bidx = q.bidx + 5'h01;
          if (q.bidx == 5'h04) begin
            if (q.dsh[2:0] != `MCHCS_CRC_OK) d.sr.block_checksum_error = 1'h1;
            if (!q.mode[`MCHCS_F_PDC] || q.sr.transmit_buffers_empty) begin
              d.sr.block_end = 1'h1;
            end
            d.dst = D_BUSY;
          end
        end
      end
      D_BUSY: if (ce && q.datf) begin
        d.sr.card_idle = 1'h1;
        d.dst = last ? D_IDLE : D_TXS;
      end
      D_RXW: begin
        if (q.tcnt >= tlim) begin
          d.sr.data_timeout = 1'h1;
          d.sr.transfer_active = 1'h0;
          d.dst = D_IDLE;
        end else if (ce && !q.datf) begin
          d.bidx = 5'h00;
          d.crc = 16'h0;
          d.wleft = q.mode[`MCHCS_F_BLKW];
          d.dst = D_RXD;
        end
      end
      D_RXD: if (ce) begin
        d.crc = crc16(q.crc, q.datf);
        d.dsh = {q.dsh[30:0], q.datf};
        d.bidx = q.bidx + 5'h01;
        if (q.bidx == 5'h1F) begin
          d.rdr = {q.dsh[30:0], q.datf};
          if (q.sr.receive_word_ready && d.sr.receive_word_ready) d.sr.receive_lost = 1'h1;
          d.sr.receive_word_ready = 1'h1;
          if (q.wleft <= 14'h1) d.dst = D_RXC;
          else d.wleft = q.wleft - 14'h1;
        end
      end
      D_RXC: if (ce) begin
        d.dsh = {q.dsh[30:0], q.datf};
        d.bidx = q.bidx + 5'h01;
        if (q.bidx == 5'h0F) begin
          if ({q.dsh[14:0], q.datf} != q.crc) d.sr.block_checksum_error = 1'h1;
          d.bidx = 5'h00;
          d.dst = D_TXE;
        end
      end
      default: d.dst = D_IDLE;
    endcase
    // A read block's end bit reuses the end state; here it only waits for the bit.
    if (q.dst == D_TXE && q.dir) begin
      d.dout = q.dout;
      d.doen = 1'h1;
      if (ce) begin
        d.tcnt = 25'h0;
        d.dst = last ? D_IDLE : D_RXW;
      end
    end

    // Shifter load: a missing word is padded and counted as starved.
    if (ld) begin
      if (d.tx_full) begin
        d.dsh = d.tdr;
        d.tx_full = 1'h0;
      end else begin
        d.dsh = q.mode[`MCHCS_F_PAD] ? 32'hFFFFFFFF : 32'h0;
        d.sr.transmit_starved = 1'h1;
      end
    end

    // Transfer counters count words only in DMA mode and chain to the next count.
    if (tdec && q.mode[`MCHCS_F_PDC] && d.tcr != 16'h0) begin
      d.tcr = d.tcr - 16'h1;
      if (d.tcr == 16'h0) begin
        d.sr.transmit_count_done = 1'h1;
        d.tcr = d.tncr;
        d.tncr = 16'h0;
      end
    end
    if (rdec && q.mode[`MCHCS_F_PDC] && d.rcr != 16'h0) begin
      d.rcr = d.rcr - 16'h1;
      if (d.rcr == 16'h0) begin
        d.sr.receive_count_done = 1'h1;
        d.rcr = d.rncr;
        d.rncr = 16'h0;
      end
    end

    // Derived flags and the masked interrupt.
    d.sr.transmit_word_taken = ~d.tx_full;
    d.sr.transmit_buffers_empty = (d.tcr == 16'h0) && (d.tncr == 16'h0);
    d.sr.receive_buffers_full = (d.rcr == 16'h0) && (d.rncr == 16'h0);
    d.irq = |(q.sr & q.imr);
  end

  // State register; reset takes constants only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.rdyo <= 1'h1;
      q.cst <= C_IDLE;
      q.dst <= D_IDLE;
      q.sr <= `MCHCS_SR_RST;
      q.cmds <= 3'h7;
      q.dats <= 3'h7;
      q.cmdf <= 1'h1;
      q.datf <= 1'h1;
      q.co <= 1'h1;
      q.coen <= 1'h1;
      q.dout <= 1'h1;
      q.doen <= 1'h1;
    end else begin
      q <= d;
    end
  end

  // Every output comes from the state register.
  assign hrdata = q.hrdata;
  assign hreadyout = q.rdyo;
  assign hresp = q.hresp;
  assign cmd_out = q.co;
  assign cmd_oe_n = q.coen;
  assign dat0_out = q.dout;
  assign dat0_oe_n = q.doen;
  assign irq = q.irq;

  // Checks on the block's own behaviour.
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_cmd_lock: assert property (q.wr && q.wa == `MCHCS_CMDR && !q.sr.command_done
    |=> $stable(q.idx) && $stable(q.transfer_command_field)) else $error("Command changed while busy.");
  a_done_clear: assert property (q.wr && q.wa == `MCHCS_CMDR && q.sr.command_done
    |=> !q.sr.command_done && q.cst == C_SEND) else $error("Command done not cleared.");
  a_resp_window: assert property (q.cst == C_WAIT
    |-> q.lcnt <= (q.lat ? `MCHCS_LAT_LONG : `MCHCS_LAT_SHORT)) else $error("Latency overrun.");
  a_resp_timeout: assert property ($rose(q.sr.response_timeout) |-> $past(q.cst) == C_WAIT
    && $past(q.lcnt) == ($past(q.lat) ? `MCHCS_LAT_LONG : `MCHCS_LAT_SHORT))
    else $error("Timeout at wrong count.");
  a_tx_empty: assert property (q.wr && (q.wa == `MCHCS_TCR || q.wa == `MCHCS_TNCR)
    && hwdata[15:0] != 16'h0 |=> !q.sr.transmit_buffers_empty)
    else $error("Transmit empty flag wrong.");
  a_rx_full: assert property (q.wr && (q.wa == `MCHCS_RCR || q.wa == `MCHCS_RNCR)
    && hwdata[15:0] != 16'h0 |=> !q.sr.receive_buffers_full)
    else $error("Receive full flag wrong.");
  a_rdr_clear: assert property (ap && !hwrite && haddr[7:0] == `MCHCS_RDR
    && q.dst != D_RXD |=> !q.sr.receive_word_ready) else $error("Ready kept after read.");
  a_idle_inactive: assert property (q.dst == D_IDLE |-> !q.sr.transfer_active)
    else $error("Transfer active while idle.");
  a_busy_release: assert property (q.dst == D_BUSY |-> q.doen)
    else $error("Data line driven during busy.");
  a_sr_clear: assert property (ap && !hwrite && haddr[7:0] == `MCHCS_SR
    && q.dst == D_IDLE |=> !q.sr.block_checksum_error && !q.sr.data_timeout)
    else $error("Error flags kept after read.");

  c_response: cover property (q.cst == C_RESP ##1 q.cst == C_IDLE);
  c_write_block: cover property (q.dst == D_STAT ##1 q.dst == D_BUSY);
  c_read_word: cover property ($rose(q.sr.receive_word_ready));
endmodule : mchcs_top

//--- tb/mchcs_card_model.sv
// Behavioural card that answers commands on the command line.
module mchcs_card_model (
  input wire logic card_clk,
  input wire logic cmd_out,
  input wire logic cmd_oe_n,
  input wire logic dat0_out,
  input wire logic dat0_oe_n,
  input wire logic rsp_on,
  input wire logic bad_idx,
  output logic card_cmd,
  output logic card_dat,
  output logic [5:0] seen_idx,
  output logic [31:0] seen_dat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [47:0] rx_q;
  logic [47:0] tx_q;
  logic [39:0] v;
  int cnt = 0;
  int gap = 0;
  int txn = 0;
  int dn = 0;
  // Checksum over the first forty bits of a response frame.
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7
  // Captures a command frame, then answers two card clocks later.
  always @(posedge card_clk) begin
    // A released line floats to its pull-up level.
    card_cmd <= (txn > 0) ? tx_q[47] : 1'b1;
    if (txn > 0) begin
      tx_q <= tx_q << 1;
      txn <= txn - 1;
    end
    if (cnt > 0) begin
      rx_q <= {rx_q[46:0], cmd_out};
      cnt <= cnt - 1;
      if (cnt == 1) gap <= 2;
    end else if (!cmd_oe_n && cmd_out == 1'b0 && txn == 0 && gap == 0) begin
      rx_q <= 48'h0;
      cnt <= 47;
    end
    if (gap > 0) begin
      gap <= gap - 1;
      if (gap == 1) begin
        seen_idx <= rx_q[45:40];
        v = {2'b00, rx_q[45:40] ^ {5'h00, bad_idx}, rx_q[39:8]};
        tx_q <= {v, crc7(v), 1'b1};
        if (rsp_on) txn <= 48;
      end
    end
    // Write block: one word, checksum and end bit are taken in after the start bit.
    if (dn == 0) begin
      if (!dat0_oe_n && dat0_out == 1'b0) dn <= 1;
    end else begin
      dn <= (dn == 59) ? 0 : dn + 1;
    end
    if (dn >= 1 && dn <= 32) seen_dat <= {seen_dat[30:0], dat0_out};
    // Good status 010 with its end bit, then four clocks of busy held low.
    card_dat <= !(dn == 50 || dn == 51 || dn == 53 || (dn >= 55 && dn <= 58));
  end
endmodule : mchcs_card_model

//--- tb/tb.sv
// Self-checking bench of the card host block.
`include "mchcs_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, card_clk = 0;
  logic rsp_on = 0, bad_idx = 0, hreadyout, hresp, irq, card_cmd;
  logic cmd_out, cmd_oe_n, dat0_out, dat0_oe_n;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [5:0] seen_idx;
  logic card_dat;
  logic [31:0] seen_dat;
  int failures = 0;
  int samples_checked = 0;
  // System clock and an unrelated card clock.
  always #4 hclk = ~hclk;
  initial #3 forever #32 card_clk = ~card_clk;
  mchcs_top u_mchcs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .card_clk(card_clk),
    .cmd_in(cmd_oe_n ? card_cmd : cmd_out), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
    .dat0_in(dat0_oe_n ? card_dat : dat0_out), .dat0_out(dat0_out), .dat0_oe_n(dat0_oe_n),
    .irq(irq));
  mchcs_card_model u_mchcs_card_model (.card_clk(card_clk), .cmd_out(cmd_out),
    .cmd_oe_n(cmd_oe_n), .dat0_out(dat0_out), .dat0_oe_n(dat0_oe_n), .rsp_on(rsp_on),
    .bad_idx(bad_idx), .card_cmd(card_cmd), .card_dat(card_dat), .seen_idx(seen_idx),
    .seen_dat(seen_dat));
  // **********
  // Bus cycles and comparisons.
  // **********
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic hold();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask : hold
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hold();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hold();
    r = hrdata;
  endtask : bus
  task automatic wait_done(input int b);
    for (int n = 0; n < 3000; n++) begin
      bus(0, 32'h40, 0);
      if (r[b] === 1'b1) return;
    end
    failures++;
    give_verdict();
  endtask : wait_done
  // **********
  // Scenarios.
  // **********
  task automatic s_reset();
    bus(0, 32'h40, 0);
    chk(r, `MCHCS_SR_RST);
    bus(0, 32'h30, 0);
    chk(r, 32'h0);
  endtask : s_reset
  task automatic s_timeout();
    bus(1, 32'h14, 32'h45);
    wait_done(0);
    chk(r & 32'h001F0000, 32'h00100000);
  endtask : s_timeout
  task automatic s_good();
    rsp_on <= 1'b1;
    bus(1, 32'h10, 32'hA5C30F1E);
    bus(1, 32'h14, 32'h45);
    bus(1, 32'h14, 32'h47);
    bus(0, 32'h40, 0);
    chk(r & 32'h1, 32'h0);
    wait_done(0);
    chk(r & 32'h001F0000, 32'h0);
    chk({26'h0, seen_idx}, 32'h5);
    bus(0, 32'h20, 0);
    chk(r, 32'hA5C30F1E);
    bus(0, 32'h20, 0);
    chk(r, 32'h0);
  endtask : s_good
  task automatic s_badidx();
    bad_idx <= 1'b1;
    bus(1, 32'h14, 32'h1045);
    wait_done(0);
    chk(r & 32'h001F0000, 32'h00010000);
    bad_idx <= 1'b0;
  endtask : s_badidx
  task automatic s_write();
    bus(1, 32'h04, 32'h00040000);
    bus(1, 32'h34, 32'h3C5A9617);
    bus(0, 32'h40, 0);
    chk(r & 32'h4, 32'h0);
    bus(1, 32'h14, 32'h10045);
    wait_done(0);
    chk(r & 32'h20, 32'h0);
    bus(0, 32'h40, 0);
    chk(r & 32'h10, 32'h10);
    wait_done(3);
    chk(r & 32'h8020003C, 32'h0000000C);
    wait_done(5);
    chk(r & 32'h28, 32'h20);
    chk(seen_dat, 32'h3C5A9617);
  endtask : s_write
  task automatic s_counters();
    for (int i = 0; i < 2; i++) begin
      bus(1, i ? 32'h5C : 32'h50, 32'h3);
      bus(0, 32'h40, 0);
      chk(r & (i ? 32'h8000 : 32'h4000), 32'h0);
      bus(1, i ? 32'h5C : 32'h50, 32'h0);
      bus(0, 32'h40, 0);
      chk(r & 32'hC000, 32'hC000);
    end
  endtask : s_counters
  task automatic s_irq();
    bus(1, 32'h4C, 32'h1);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    bus(1, 32'h4C, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
  endtask : s_irq
  // Resets the block and runs every scenario once.
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_timeout();
    s_good();
    s_badidx();
    s_write();
    s_counters();
    s_irq();
    give_verdict();
  end
endmodule : tb
